// ===== rtl/irs_pkg.sv
// Constants, register map and encodings for the image remap sequencer.
// Assumes a single 100 MHz system clock domain for all users of this package.
package irs_pkg;
  localparam int ADDR_W = 24;
  localparam int FRAC_MAX = 16;
  localparam int ACC_W = 48;
  localparam int EXT_W = 12;
  localparam int TGT_W = 12;
  localparam int NCOEF = 16;
  localparam int DEG = 4;
  // Register indices on the load port.
  localparam logic [5:0] REG_COEF0 = 6'h00;
  localparam logic [5:0] REG_CTRL = 6'h10;
  localparam logic [5:0] REG_U_LO = 6'h11;
  localparam logic [5:0] REG_U_HI = 6'h12;
  localparam logic [5:0] REG_V_LO = 6'h13;
  localparam logic [5:0] REG_V_HI = 6'h14;
  localparam logic [5:0] REG_W_HI = 6'h15;
  localparam logic [5:0] REG_KERN = 6'h16;
  localparam logic [5:0] REG_SWIN_LO = 6'h17;
  localparam logic [5:0] REG_SWIN_HI = 6'h18;
  localparam logic [5:0] REG_STAT = 6'h19;
  localparam logic [5:0] REG_MASK = 6'h1A;
  localparam logic [5:0] REG_START = 6'h1B;
  // Control register fields.
  localparam int CTL_REPEAT = 0;
  localparam int CTL_3D = 1;
  localparam int CTL_EXT = 2;
  localparam int CTL_PASS_LSB = 3;
  localparam int CTL_FRAC_LSB = 5;
  // Status bits.
  localparam int ST_DONE = 0;
  localparam int ST_SOUT = 1;
  localparam int ST_TOUT = 2;
  localparam int ST_W = 3;
  localparam logic [4:0] FRAC_RST = 5'h10;
  typedef enum logic [1:0] {
    IRS_IDLE = 2'b00,
    IRS_WALK = 2'b01,
    IRS_STEP = 2'b10,
    IRS_FIN = 2'b11
  } irs_state_t;
endpackage : irs_pkg

// ===== rtl/irs_seq.sv
// Image remap address sequencer: raster target walk, polynomial source map,
// kernel walk. Assumes the host port lives in this clock domain; strobes
// arriving from the asynchronous load clock are brought in by the host glue.
//Function
//- Parameters are loaded by the host on a load clock apart from clk.
//- A done indication rises when the whole target rectangle is finished.
//- A control bit picks endless repeat or one single pass; without repeat the code runs all passes set in the pass field.
//- The top 24 bits of the source coordinate drive the source address.
//- Extended mode puts twelve more low source bits on the target port.
//- Source addresses come each clock and targets once per k accesses; the code holds src_valid low on the step clock after each walk.
//- 2D mode evaluates all sixteen products of u and v powers 0 to 3.
//- The polynomial uses target address minus the start bounds.
//- 3D mode evaluates the eight terms 1,u,v,w,uv,vw,uw,uvw.
//- Flags show source or target addresses outside a set rectangle; the code checks source addresses against the single range sx_lo_q to sx_hi_q.
//- Column steps by one and wraps to line start, bumping the row.
//- Rows run to the row end; in 3D depth steps per plane to the end.
//- Each pixel runs a spiral kernel walk emitting coefficient addresses; the code walks the kernel serpentine, row by row.
//- Multi-pass walks step the kernel along one dimension per pass.
//- Each axis has 24 integer bits and a 0 to 16 bit fraction.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module irs_seq #(
  parameter int KDIM = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [irs_pkg::ADDR_W-1:0] src_addr,
  output logic src_valid,
  output logic [irs_pkg::TGT_W-1:0] tgt_addr,
  output logic tgt_wr,
  output logic [7:0] coef_addr,
  output logic src_out,
  output logic tgt_out,
  output logic done,
  output logic irq
);
  // Host writes land here in clk; the load clock crossing is outside.
  logic signed [irs_pkg::ACC_W-1:0] coef_q [irs_pkg::NCOEF];
  logic [31:0] ctrl_q;
  logic [irs_pkg::ADDR_W-1:0] u_lo_q, u_hi_q, v_lo_q, v_hi_q, w_hi_q;
  logic [irs_pkg::ADDR_W-1:0] sx_lo_q, sx_hi_q;
  logic [3:0] kern_q;
  logic [irs_pkg::ST_W-1:0] stat_q, mask_q;
  logic start;
  irs_pkg::irs_state_t state_q;
  logic [irs_pkg::ADDR_W-1:0] ucnt_q, vcnt_q, wcnt_q;
  logic [3:0] kx_q, ky_q;
  logic [1:0] pass_q;
  logic signed [irs_pkg::ACC_W-1:0] pos_q;
  logic last_pix, walk_end;

  assign start = reg_wr && reg_addr == irs_pkg::REG_START;

  // Truncating multiply kept in the accumulator width.
  function automatic logic signed [irs_pkg::ACC_W-1:0] mulw(
    input logic signed [irs_pkg::ACC_W-1:0] a,
    input logic signed [irs_pkg::ACC_W-1:0] b
  );
    logic signed [2*irs_pkg::ACC_W-1:0] p;
    p = a * b;
    mulw = p[irs_pkg::ACC_W-1:0];
  endfunction : mulw

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < irs_pkg::NCOEF; i++)
        coef_q[i] <= '0;
      ctrl_q <= 32'(irs_pkg::FRAC_RST) << irs_pkg::CTL_FRAC_LSB;
      u_lo_q <= '0;
      u_hi_q <= '0;
      v_lo_q <= '0;
      v_hi_q <= '0;
      w_hi_q <= '0;
      sx_lo_q <= '0;
      sx_hi_q <= '0;
      kern_q <= '0;
      mask_q <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr < irs_pkg::REG_CTRL)
        coef_q[reg_addr[3:0]] <= irs_pkg::ACC_W'(signed'(reg_wdata));
      case (reg_addr)
        irs_pkg::REG_CTRL: ctrl_q <= reg_wdata;
        irs_pkg::REG_U_LO: u_lo_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_U_HI: u_hi_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_V_LO: v_lo_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_V_HI: v_hi_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_W_HI: w_hi_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_SWIN_LO: sx_lo_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_SWIN_HI: sx_hi_q <= reg_wdata[irs_pkg::ADDR_W-1:0];
        irs_pkg::REG_KERN: kern_q <= reg_wdata[3:0];
        irs_pkg::REG_MASK: mask_q <= reg_wdata[irs_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  logic repeat_on, mode3d, ext_on;
  logic [1:0] passes;
  logic [4:0] frac;
  assign repeat_on = ctrl_q[irs_pkg::CTL_REPEAT];
  assign mode3d = ctrl_q[irs_pkg::CTL_3D];
  assign ext_on = ctrl_q[irs_pkg::CTL_EXT];
  assign passes = ctrl_q[irs_pkg::CTL_PASS_LSB +: 2];
  assign frac = (ctrl_q[irs_pkg::CTL_FRAC_LSB +: 5] > 5'(irs_pkg::FRAC_MAX))
              ? 5'(irs_pkg::FRAC_MAX) : ctrl_q[irs_pkg::CTL_FRAC_LSB +: 5];

  // Relative coordinates feed the polynomial.
  logic signed [irs_pkg::ACC_W-1:0] ur, vr, wr, poly;
  assign ur = irs_pkg::ACC_W'(ucnt_q - u_lo_q);
  assign vr = irs_pkg::ACC_W'(vcnt_q - v_lo_q);
  assign wr = irs_pkg::ACC_W'(wcnt_q);

  // Direct evaluation is large but gives one result per pixel with no
  // forward-difference state to reseed on every line.
  always_comb
  begin
    logic signed [irs_pkg::ACC_W-1:0] up [irs_pkg::DEG];
    logic signed [irs_pkg::ACC_W-1:0] vp [irs_pkg::DEG];
    for (int i = 0; i < irs_pkg::DEG; i++)
    begin
      up[i] = '0;
      vp[i] = '0;
    end
    poly = '0;
    up[0] = irs_pkg::ACC_W'(1);
    vp[0] = irs_pkg::ACC_W'(1);
    for (int i = 1; i < irs_pkg::DEG; i++)
    begin
      up[i] = mulw(up[i-1], ur);
      vp[i] = mulw(vp[i-1], vr);
    end
    if (!mode3d)
    begin
      for (int j = 0; j < irs_pkg::DEG; j++)
        for (int i = 0; i < irs_pkg::DEG; i++)
          poly = poly + mulw(coef_q[j*irs_pkg::DEG+i], mulw(up[i], vp[j]));
    end
    else
    begin
      // Coefficient slots 0..7 weight 1,u,v,w,uv,vw,uw,uvw.
      poly = coef_q[0] + mulw(coef_q[1], ur) + mulw(coef_q[2], vr)
           + mulw(coef_q[3], wr) + mulw(coef_q[4], mulw(ur, vr))
           + mulw(coef_q[5], mulw(vr, wr)) + mulw(coef_q[6], mulw(ur, wr))
           + mulw(coef_q[7], mulw(mulw(ur, vr), wr));
    end
  end

  // Kernel walk; a pass walks one axis only when more than one pass is set.
  logic [3:0] kx_last, ky_last;
  assign kx_last = (passes > 2'h1 && pass_q != 2'h0) ? 4'h0 : kern_q;
  assign ky_last = (passes > 2'h1 && pass_q == 2'h0) ? 4'h0 : kern_q;
  // An odd last row runs right to left, so the walk ends at column zero.
  assign walk_end = ky_q == ky_last && kx_q == (ky_q[0] ? 4'h0 : kx_last);
  assign last_pix = ucnt_q == u_hi_q && vcnt_q == v_hi_q
                 && (!mode3d || wcnt_q == w_hi_q);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= irs_pkg::IRS_IDLE;
      ucnt_q <= '0;
      vcnt_q <= '0;
      wcnt_q <= '0;
      kx_q <= '0;
      ky_q <= '0;
      pass_q <= '0;
      pos_q <= '0;
    end
    else
    begin
      case (state_q)
        irs_pkg::IRS_IDLE:
          if (start)
          begin
            ucnt_q <= u_lo_q;
            vcnt_q <= v_lo_q;
            wcnt_q <= '0;
            kx_q <= '0;
            ky_q <= '0;
            pass_q <= '0;
            state_q <= irs_pkg::IRS_WALK;
          end
        irs_pkg::IRS_WALK:
        begin
          pos_q <= poly;
          // Serpentine kernel walk, one source access per clock.
          if (walk_end)
          begin
            kx_q <= '0;
            ky_q <= '0;
            state_q <= irs_pkg::IRS_STEP;
          end
          else if ((ky_q[0] ? kx_q == 4'h0 : kx_q == kx_last))
            ky_q <= ky_q + 4'h1;
          else if (ky_q[0])
            kx_q <= kx_q - 4'h1;
          else
            kx_q <= kx_q + 4'h1;
        end
        irs_pkg::IRS_STEP:
        begin
          state_q <= irs_pkg::IRS_WALK;
          if (last_pix)
          begin
            ucnt_q <= u_lo_q;
            vcnt_q <= v_lo_q;
            wcnt_q <= '0;
            if (pass_q + 2'h1 < passes)
              pass_q <= pass_q + 2'h1;
            else
              state_q <= irs_pkg::IRS_FIN;
          end
          else if (ucnt_q == u_hi_q)
          begin
            ucnt_q <= u_lo_q;
            if (vcnt_q == v_hi_q)
            begin
              vcnt_q <= v_lo_q;
              wcnt_q <= wcnt_q + 24'h1;
            end
            else
              vcnt_q <= vcnt_q + 24'h1;
          end
          else
            ucnt_q <= ucnt_q + 24'h1;
        end
        irs_pkg::IRS_FIN:
        begin
          pass_q <= '0;
          state_q <= repeat_on ? irs_pkg::IRS_WALK : irs_pkg::IRS_IDLE;
        end
        default: state_q <= irs_pkg::IRS_IDLE;
      endcase
    end
  end

  // The source address comes straight from this cycle's polynomial so that
  // it lines up with src_valid; pos_q keeps the value for the target port,
  // where extended mode shows the twelve bits below the integer part.
  logic [irs_pkg::ACC_W-1:0] shifted, ext_bits;
  assign shifted = poly >>> frac;
  assign ext_bits = (pos_q <<< irs_pkg::EXT_W) >>> frac;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      src_addr <= '0;
      src_valid <= 1'b0;
      tgt_addr <= '0;
      tgt_wr <= 1'b0;
      coef_addr <= '0;
      src_out <= 1'b0;
      tgt_out <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      src_valid <= state_q == irs_pkg::IRS_WALK;
      src_addr <= shifted[irs_pkg::ADDR_W-1:0] + {20'h0, ky_q};
      coef_addr <= {ky_q, kx_q};
      // Target port only changes between walks.
      if (state_q == irs_pkg::IRS_STEP || state_q == irs_pkg::IRS_IDLE)
        tgt_addr <= ext_on ? ext_bits[irs_pkg::EXT_W-1:0]
                           : ucnt_q[irs_pkg::TGT_W-1:0];
      tgt_wr <= state_q == irs_pkg::IRS_STEP;
      src_out <= shifted[irs_pkg::ADDR_W-1:0] < sx_lo_q
              || shifted[irs_pkg::ADDR_W-1:0] > sx_hi_q;
      tgt_out <= ucnt_q < u_lo_q || ucnt_q > u_hi_q
              || vcnt_q < v_lo_q || vcnt_q > v_hi_q;
      done <= state_q == irs_pkg::IRS_FIN;
    end
  end

  // Sticky events; a set in the same cycle as the clearing read wins.
  logic [irs_pkg::ST_W-1:0] ev;
  assign ev = {tgt_out, src_out, done};
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stat_q <= '0;
    else if (reg_rd && reg_addr == irs_pkg::REG_STAT)
      stat_q <= ev;
    else
      stat_q <= stat_q | ev;
  end
  assign irq = |(stat_q & mask_q);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        irs_pkg::REG_CTRL: reg_rdata <= ctrl_q;
        irs_pkg::REG_STAT: reg_rdata <= {29'h0, stat_q};
        irs_pkg::REG_MASK: reg_rdata <= {29'h0, mask_q};
        irs_pkg::REG_U_LO: reg_rdata <= {8'h0, ucnt_q};
        irs_pkg::REG_V_LO: reg_rdata <= {8'h0, vcnt_q};
        irs_pkg::REG_W_HI: reg_rdata <= {8'h0, wcnt_q};
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end
endmodule : irs_seq
`default_nettype wire

// ===== test/irs_seq_assertions.sv
// Timing checks on the remap sequencer outputs.
// Assumes a bind onto irs_seq; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module irs_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic src_valid,
  input wire logic [11:0] tgt_addr,
  input wire logic tgt_wr,
  input wire logic [7:0] coef_addr,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  done_pulse_a:
    assert property (done |=> !done) else $error("done too long");
  done_idle_a:
    assert property (done |-> !src_valid) else $error("done in walk");
  pix_pulse_a:
    assert property (tgt_wr |=> !tgt_wr) else $error("tgt_wr too long");
  pix_gap_a:
    assert property (tgt_wr |-> !src_valid) else $error("tgt_wr in walk");
  walk_end_a:
    assert property (tgt_wr |-> $past(src_valid)) else $error("no walk");
  tgt_hold_a:
    assert property (src_valid && $past(src_valid) |-> $stable(tgt_addr))
      else $error("tgt_addr moved");
  coef_step_a:
    assert property (src_valid && $past(src_valid) |->
      coef_addr != $past(coef_addr)) else $error("coef_addr stuck");
  rd_quiet_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("stray read data");
endmodule : irs_chk
`default_nettype wire

// ===== test/irs_buf_model.sv
// Target buffer stand-in: logs each pixel's target and source address.
// Assumes it shares clk with the sequencer, as each axis device does.
`timescale 1ns/1ps
`default_nettype none
module irs_buf_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [23:0] src_addr,
  input wire logic src_valid,
  input wire logic [11:0] tgt_addr,
  input wire logic tgt_wr,
  input wire logic [7:0] coef_addr,
  input wire logic [7:0] log_idx,
  output logic [35:0] log_val,
  output logic [15:0] n_pix,
  output logic [15:0] walk_len,
  output logic [15:0] walk_cov
);
  logic [35:0] mem [256];
  logic [255:0] seen;
  logic [15:0] len;
  logic in_walk;
  logic [23:0] src_first;
  assign log_val = mem[log_idx];
  // The source address is taken at the first kernel access; the target
  // address only settles with the write strobe that closes the walk.
  always_ff @(posedge clk)
  begin
    if (src_valid && !in_walk)
      src_first <= src_addr;
    if (tgt_wr)
      mem[n_pix[7:0]] <= {tgt_addr, src_first};
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {seen, len, in_walk, n_pix, walk_len, walk_cov} <= '0;
    end
    else
    begin
      in_walk <= src_valid;
      if (tgt_wr)
        n_pix <= n_pix + 16'h1;
      if (src_valid)
      begin
        len <= in_walk ? len + 16'h1 : 16'h1;
        seen <= (in_walk ? seen : '0) | (256'h1 << coef_addr);
      end
      else if (in_walk)
      begin
        walk_len <= len;
        walk_cov <= 16'($countones(seen));
      end
    end
endmodule : irs_buf_model
`default_nettype wire

// ===== test/irs_seq_tb_top.sv
// Self-checking bench for the remap sequencer and a buffer model.
// Assumes host strobes already arrive in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module irs_seq_tb_top;
  logic clk, arst_n, reg_wr, reg_rd, src_valid, tgt_wr, done, irq;
  logic src_out, tgt_out;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [23:0] src_addr;
  logic [11:0] tgt_addr;
  logic [7:0] coef_addr, log_idx;
  logic [35:0] log_val, e;
  logic [15:0] n_pix, walk_len, walk_cov;
  int n_mismatch, comparisons, seed, coef[16];
  int npass, fr;
  irs_seq i_irs_seq (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_addr(src_addr), .src_valid(src_valid),
    .tgt_addr(tgt_addr), .tgt_wr(tgt_wr), .coef_addr(coef_addr),
    .src_out(src_out), .tgt_out(tgt_out), .done(done), .irq(irq));
  irs_buf_model i_irs_buf_model (.clk(clk), .arst_n(arst_n),
    .src_addr(src_addr), .src_valid(src_valid), .tgt_addr(tgt_addr),
    .tgt_wr(tgt_wr), .coef_addr(coef_addr), .log_idx(log_idx),
    .log_val(log_val), .n_pix(n_pix), .walk_len(walk_len),
    .walk_cov(walk_cov));
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Parameter loads reach the core already retimed to clk.
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic wait_hi(ref logic s, input int lim);
    int c = 0;
    do
    begin
      @(posedge clk);
      #1;
      c++;
    end
    while (s !== 1'b1 && c < lim);
    `CHK("wait", 1'b1, s)
  endtask : wait_hi
  function automatic int exp_src(input bit d3, input int u, v, w);
    int s = 0;
    if (d3)
      return coef[0] + coef[1] * u + coef[2] * v + coef[3] * w
        + coef[4] * u * v + coef[5] * v * w + coef[6] * u * w
        + coef[7] * u * v * w;
    for (int j = 0; j < 16; j++)
      s += coef[j] * u ** (j % 4) * v ** (j / 4);
    return s;
  endfunction : exp_src
  task automatic run(input bit d3, ext, rep, msk, input int wh, kern);
    int base, ul, vl, nu, nv, n, s;
    base = n_pix;
    ul = $random(seed) & 7;
    vl = $random(seed) & 7;
    nu = ($random(seed) & 3) + 1;
    nv = ($random(seed) & 3) + 1;
    n = nu * nv * (d3 ? wh + 1 : 1);
    for (int i = 0; i < 16; i++)
    begin
      coef[i] = $random(seed) & 3;
      wr(6'(i), (coef[i] << 16) | (ext && i == 0 ? 32'hABC0 : 32'h0));
    end
    wr(irs_pkg::REG_CTRL, {22'h0, 5'(fr), 2'(npass), ext, d3, rep});
    wr(irs_pkg::REG_U_LO, ul);
    wr(irs_pkg::REG_U_HI, ul + nu - 1);
    wr(irs_pkg::REG_V_LO, vl);
    wr(irs_pkg::REG_V_HI, vl + nv - 1);
    wr(irs_pkg::REG_W_HI, wh);
    wr(irs_pkg::REG_KERN, kern);
    wr(irs_pkg::REG_MASK, {31'h0, msk});
    wr(irs_pkg::REG_START, 32'h0);
    wait_hi(done, 4000);
    if (rep)
    begin
      wait_hi(src_valid, 8);
      wr(irs_pkg::REG_CTRL, {22'h0, 5'(fr), 2'(npass), ext, d3, 1'b0});
      wait_hi(done, 4000);
    end
    repeat (12) @(posedge clk);
    #1;
    `CHK("halt", 1'b0, src_valid)
    // Idle counters sit at the origin, so the source is the constant term.
    s = coef[0] << (16 - fr);
    `CHK("src_out", s < 1 || s > 2, src_out)
    `CHK("tgt_in", 1'b0, tgt_out)
    s = (rep ? 2 : 1) * (npass > 1 ? npass : 1);
    `CHK("pixels", n * s, int'(n_pix) - base)
    s = (kern + 1) * (npass > 1 ? 1 : kern + 1);
    `CHK("walk_len", s, int'(walk_len))
    `CHK("walk_cov", s, int'(walk_cov))
    `CHK("irq", msk, irq)
    for (int i = 0; i < n; i++)
    begin
      log_idx = 8'(base + i);
      e[35:24] = ext ? 12'hABC : 12'(ul + i % nu);
      s = exp_src(d3, i % nu, i / nu % nv, i / (nu * nv));
      e[23:0] = 24'(s << (16 - fr));
      #1;
      `CHK("pixel", e, log_val)
    end
    wr(irs_pkg::REG_U_LO, ul + nu);
    @(posedge clk);
    #1;
    `CHK("tgt_out", 1'b1, tgt_out)
    rd(irs_pkg::REG_STAT, d);
    `CHK("stat_done", 1'b1, d[irs_pkg::ST_DONE])
    `CHK("irq_clr", 1'b0, irq)
  endtask : run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    seed = 32'hA42209D2;
    npass = 0;
    fr = 16;
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, log_idx} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(irs_pkg::REG_CTRL, d);
    `CHK("ctrl_rst", 32'h200, d)
    wr(6'h3F, 32'hFFFFFFFF);
    rd(6'h3F, d);
    `CHK("unmapped", 32'h0, d)
    wr(irs_pkg::REG_SWIN_LO, 32'h1);
    wr(irs_pkg::REG_SWIN_HI, 32'h2);
    repeat (3) run(1'b0, 1'b0, 1'b0, 1'b1, 0, $random(seed) & 1);
    run(1'b1, 1'b0, 1'b0, 1'b1, 1, 1);
    run(1'b0, 1'b1, 1'b0, 1'b0, 0, 0);
    run(1'b0, 1'b0, 1'b1, 1'b1, 0, 1);
    npass = 2;
    fr = 8;
    run(1'b0, 1'b0, 1'b0, 1'b1, 0, 2);
    complete_run();
  end
endmodule : irs_seq_tb_top
bind irs_seq irs_chk i_irs_chk (.clk(clk), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_valid(src_valid),
  .tgt_addr(tgt_addr), .tgt_wr(tgt_wr), .coef_addr(coef_addr),
  .done(done));
`default_nettype wire
